// ### slbp_cfg.svh
// constants of the packet buffer port: widths, sizes and counts
// assumes nothing; included by the package and both ends
`ifndef SLBP_CFG_SVH
`define SLBP_CFG_SVH

`define SLBP_WIDTH         32
`define SLBP_WIDTH_WIDE    64
`define SLBP_BUF_BYTES     32768
`define SLBP_BLOCK_BYTES   64
`define SLBP_MAX_PKT_BYTES 276
`define SLBP_OVF_LATE      3
`define SLBP_DAV_MARGIN    4

`endif

// ### slbp_dev.sv
// link end of the packet port: transmit and receive packet buffers
// assumes one clock for port and link sides, link words from a phy
`timescale 1ns/1ps
`include "slbp_cfg.svh"

// Functional notes
// RULE1: port 32 bits, 64 for fast quad
// RULE2: sink on transmit, source on receive
// RULE3: data-available when a whole packet buffered
// RULE4: early start after first 64-byte block
// RULE5: cut-through in both directions
// RULE6: late error gives error with end-of-packet
// RULE7: reader discards packets flagged with error
// RULE8: writer aborts with error plus end-of-packet
// RULE9: abort after link start ends with stomp
// RULE10: late start after space drop is dropped
// RULE11: receive error holds until end-of-packet
// RULE12: crc error pulses one cycle, flags packet
// RULE13: not-accepted output with not-accepted symbol
// RULE14: stomp flags packet and later until restart
// RULE15: oversize packet cut at 276 bytes
// RULE16: no room for accept symbol flags error
// RULE17: corrupted embedded symbol flags packet error
// RULE18: bad character ends packet, rest dropped
// RULE19: both link ends use same mode, rate
// RULE20: queued buffering up to 32 kilobytes each
// RULE21: one clock here, status read synchronously
module slbp_dev
  import slbp_pkg::*;
#(
  parameter int unsigned W         = `SLBP_WIDTH,     // [RULE1] [RULE19]
  parameter int unsigned BUF_BYTES = `SLBP_BUF_BYTES  // [RULE20]
) (
  input  wire logic         i_clock,
  input  wire logic         i_arst_n,
  slbp_port_if.dev          port,
  output wire logic         o_lk_tx_val,
  input  wire logic         i_lk_tx_rdy,
  output wire logic         o_lk_tx_sop,
  output wire logic         o_lk_tx_eop,
  output wire logic         o_lk_tx_stomp,
  output wire logic [W-1:0] o_lk_tx_dat,
  input  wire logic         i_lk_rx_val,
  input  wire logic         i_lk_rx_sop,
  input  wire logic         i_lk_rx_eop,
  input  wire logic [W-1:0] i_lk_rx_dat,
  input  wire logic         i_lk_crc_err,
  input  wire logic         i_lk_stomp,
  input  wire logic         i_lk_restart,
  input  wire logic         i_lk_sym_err,
  input  wire logic         i_lk_char_err,
  input  wire logic         i_lk_ack_full,
  output wire logic         o_crc_err,
  output wire logic         o_not_accepted
);
  localparam int unsigned BPW   = W / 8;
  localparam int unsigned DEPTH = BUF_BYTES / BPW;
  localparam int unsigned AW    = $clog2(DEPTH);
  localparam int unsigned PW    = AW + 1;
  localparam int unsigned MW    = W + 3;
  localparam int unsigned MAXW  = (`SLBP_MAX_PKT_BYTES + BPW - 1) / BPW;
  localparam int unsigned CW    = $clog2(MAXW + 1);
  localparam logic [PW-1:0] FULL   = PW'(DEPTH);
  localparam logic [PW-1:0] BLKW   = PW'(`SLBP_BLOCK_BYTES / BPW);
  localparam logic [PW-1:0] MARGIN = PW'(`SLBP_DAV_MARGIN);
  localparam logic [CW-1:0] LASTW  = CW'(MAXW - 1);
  localparam logic [1:0]    LATE   = 2'(`SLBP_OVF_LATE);

  // memory word: {sop, eop, err, data}
  typedef struct packed {
    logic [PW-1:0]       tw;
    logic [PW-1:0]       tr;
    logic                tx_drop;
    logic [1:0]          late;
    logic                tx_ovf;
    logic [MW-1:0]       sk0;
    logic [MW-1:0]       sk1;
    logic [1:0]          skn;
    logic [PW-1:0]       rw;
    logic [PW-1:0]       rr;
    logic [PW-1:0]       pkts;
    logic                in_pkt;
    logic                bad;
    logic                discard;
    logic                stomp_win;
    logic [CW-1:0]       wcnt;
    logic                crc;
    logic                pna;
    slbp_rd_state_t      st;
    logic                err_hold;
    logic                o_val;
    logic                o_sop;
    logic                o_eop;
    logic                o_err;
    logic [W-1:0]        o_dat;
  } slbp_dev_state_t;

  slbp_dev_state_t q;
  slbp_dev_state_t d;
  logic [MW-1:0]   tx_mem [DEPTH];
  logic [MW-1:0]   rx_mem [DEPTH];
  logic            tx_we;
  logic [MW-1:0]   tx_wd;
  logic            rx_we;
  logic [MW-1:0]   rx_wd;
  logic            tx_dav_w;

  // margin covers the writer's reaction time before overflow applies
  assign tx_dav_w = (FULL - (q.tw - q.tr)) > MARGIN;

  always_comb begin
    logic          late_now;
    logic          drop_now;
    logic          push;
    logic          pop;
    logic [1:0]    n;
    logic [MW-1:0] rdw;
    logic          pinc;
    logic          pdec;
    logic          rfull;
    logic          term;
    logic          wflag;
    logic          ok;
    late_now = 1'b0;
    drop_now = 1'b0;
    push     = 1'b0;
    pop      = 1'b0;
    n        = 2'h0;
    rdw      = rx_mem[q.rr[AW-1:0]];
    pinc     = 1'b0;
    pdec     = 1'b0;
    rfull    = (q.rw - q.rr) == FULL;
    term     = 1'b0;
    wflag    = 1'b0;
    ok       = 1'b0;
    d        = q;
    tx_we    = 1'b0;
    tx_wd    = '0;
    rx_we    = 1'b0;
    rx_wd    = '0;
    d.tx_ovf = 1'b0;
    d.crc    = 1'b0;
    d.pna    = 1'b0;

    // transmit write side
    if (tx_dav_w) begin
      d.late = 2'h0;
    end else if (q.late != LATE) begin
      d.late = q.late + 2'h1;
    end
    late_now = !tx_dav_w && (q.late == LATE);
    if (port.tx_ena) begin
      drop_now = port.tx_sop ? late_now : q.tx_drop;
      if (port.tx_sop) begin
        d.tx_drop = late_now;                                  // [RULE10]
        d.tx_ovf  = late_now;                                  // [RULE10]
      end
      if (!drop_now && (q.tw - q.tr) != FULL) begin
        tx_we = 1'b1;
        tx_wd = {port.tx_sop, port.tx_eop, port.tx_err, port.tx_dat};
        d.tw  = q.tw + 1'b1;
      end
      if (port.tx_eop) begin
        d.tx_drop = 1'b0;
      end
    end

    // words leave as soon as buffered, no wait for end-of-packet
    pop  = (q.skn != 2'h0) && i_lk_tx_rdy;
    push = (q.tr != q.tw) && (q.skn != 2'h2);                  // [RULE5]
    n    = q.skn - {1'b0, pop};
    if (pop) begin
      d.sk0 = q.sk1;
    end
    if (push) begin
      if (n == 2'h0) begin
        d.sk0 = tx_mem[q.tr[AW-1:0]];
      end else begin
        d.sk1 = tx_mem[q.tr[AW-1:0]];
      end
      d.tr = q.tr + 1'b1;
    end
    d.skn = n + {1'b0, push};

    // receive write side
    if (i_lk_restart) begin
      d.stomp_win = 1'b0;                                      // [RULE14]
    end
    if (i_lk_stomp) begin
      d.stomp_win = 1'b1;                                      // [RULE14]
      term        = q.in_pkt;
    end
    if (i_lk_char_err && q.in_pkt) begin
      term      = 1'b1;                                        // [RULE18]
      d.discard = 1'b1;                                        // [RULE18]
    end
    if (i_lk_crc_err || i_lk_sym_err || i_lk_char_err) begin
      d.pna = 1'b1;                                            // [RULE13]
    end
    if (i_lk_crc_err && i_lk_rx_val && i_lk_rx_eop) begin
      d.crc = 1'b1;                                            // [RULE12]
    end
    if (term) begin
      // closing word ends the cut-off packet with an error
      rx_we    = !rfull;                                       // [RULE6]
      rx_wd    = {1'b0, 1'b1, 1'b1, {W{1'b0}}};
      pinc     = !rfull;
      d.in_pkt = 1'b0;
      d.bad    = 1'b0;
    end else if (i_lk_rx_val && q.discard) begin
      d.discard = !i_lk_rx_eop;
    end else if (i_lk_rx_val) begin
      wflag = (i_lk_rx_sop ? q.stomp_win : q.bad)              // [RULE14]
            | i_lk_sym_err                                     // [RULE17]
            | (i_lk_rx_eop & (i_lk_crc_err | i_lk_ack_full));  // [RULE12] [RULE16]
      d.bad  = wflag;
      d.wcnt = i_lk_rx_sop ? CW'(1) : q.wcnt + 1'b1;
      if (!i_lk_rx_eop && !i_lk_rx_sop && q.wcnt == LASTW) begin
        // oversize: this word becomes the last, the rest is thrown away
        d.discard = 1'b1;                                      // [RULE15]
        wflag     = 1'b1;                                      // [RULE15]
      end
      // an overrun word is lost; the packet is flagged instead
      if (rfull) begin
        d.bad = 1'b1;
      end
      rx_we    = !rfull;
      rx_wd    = {i_lk_rx_sop, i_lk_rx_eop | d.discard, wflag, i_lk_rx_dat};
      pinc     = !rfull && (i_lk_rx_eop || d.discard);
      d.in_pkt = !(i_lk_rx_eop || d.discard);
    end
    if (rx_we) begin
      d.rw = q.rw + 1'b1;
    end

    // receive read side
    ok = (q.rr != q.rw)
       && ((q.st == SLBP_RD_BUSY)
           || (q.pkts != '0)                                   // [RULE3]
           || ((q.rw - q.rr) >= BLKW));                        // [RULE4]
    if (!q.o_val || port.rx_ena) begin
      d.o_val = 1'b0;
      if (ok) begin
        d.o_val    = 1'b1;
        d.o_sop    = rdw[MW-1];
        d.o_eop    = rdw[MW-2];
        d.o_err    = rdw[MW-3] | (q.err_hold & !rdw[MW-1]);    // [RULE11]
        d.o_dat    = rdw[W-1:0];
        d.err_hold = d.o_err & !rdw[MW-2];                     // [RULE11]
        d.st       = rdw[MW-2] ? SLBP_RD_IDLE : SLBP_RD_BUSY;
        d.rr       = q.rr + 1'b1;
        pdec       = rdw[MW-2];
      end
    end
    d.pkts = q.pkts + PW'(pinc) - PW'(pdec);
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q    <= '0;
      q.st <= SLBP_RD_IDLE;
    end else begin
      q <= d;
    end
  end

  // buffer arrays hold no control state, so they skip the reset
  always_ff @(posedge i_clock) begin
    if (tx_we) begin
      tx_mem[q.tw[AW-1:0]] <= tx_wd;
    end
    if (rx_we) begin
      rx_mem[q.rw[AW-1:0]] <= rx_wd;
    end
  end

  assign port.tx_dav    = tx_dav_w;                            // [RULE21]
  assign port.tx_ovf    = q.tx_ovf;
  assign port.rx_dav    = q.pkts != '0;                        // [RULE3]
  assign port.rx_val    = q.o_val;                             // [RULE2]
  assign port.rx_sop    = q.o_sop;
  assign port.rx_eop    = q.o_eop;
  assign port.rx_err    = q.o_err & q.o_val;                   // [RULE11]
  assign port.rx_dat    = q.o_dat;
  assign o_lk_tx_val    = q.skn != 2'h0;
  assign o_lk_tx_sop    = q.sk0[MW-1];
  assign o_lk_tx_eop    = q.sk0[MW-2];
  assign o_lk_tx_stomp  = q.sk0[MW-2] & q.sk0[MW-3];           // [RULE9]
  assign o_lk_tx_dat    = q.sk0[W-1:0];
  assign o_crc_err      = q.crc;                               // [RULE12]
  assign o_not_accepted = q.pna;                               // [RULE13]
endmodule // slbp_dev

// ### slbp_monitor.sv
// checker on the packet port between user end and device end
// assumes one clock; every input other than clock and reset is a wire of the port
`timescale 1ns/1ps
`include "slbp_cfg.svh"

module slbp_monitor #(
  parameter int unsigned W = 32
) (
  input wire logic         i_clock,
  input wire logic         i_arst_n,
  input wire logic         tx_ena,
  input wire logic         tx_sop,
  input wire logic         tx_eop,
  input wire logic         tx_err,
  input wire logic [W-1:0] tx_dat,
  input wire logic         tx_dav,
  input wire logic         tx_ovf,
  input wire logic         rx_ena,
  input wire logic         rx_dav,
  input wire logic         rx_val,
  input wire logic         rx_sop,
  input wire logic         rx_eop,
  input wire logic         rx_err,
  input wire logic [W-1:0] rx_dat
);
  localparam int LAST = (`SLBP_MAX_PKT_BYTES * 8 + W - 1) / W - 1;
  logic       in_q;
  logic       bad_q;
  logic [7:0] cnt_q;

  // position inside the packet being read
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      in_q  <= 1'b0;
      bad_q <= 1'b0;
      cnt_q <= 8'h00;
    end else if (rx_val && rx_ena) begin
      in_q  <= !rx_eop;
      bad_q <= !rx_eop && (bad_q || rx_err);
      cnt_q <= rx_eop ? 8'h00 : cnt_q + 8'h01;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  sequence late_sop;
    !tx_dav [*3] ##1 (tx_ena && tx_sop && !tx_dav);
  endsequence
  sequence pkt_waiting;
    rx_dav && rx_ena && !rx_val;
  endsequence

  a_late_sop_drop: assert property (late_sop |=> tx_ovf)
    else $error("late packet start not reported");
  a_ovf_cause: assert property (tx_ovf |->
    $past(tx_ena) && $past(tx_sop) && !$past(tx_dav) && !$past(tx_dav, 3))
    else $error("overflow without a late start");
  a_ovf_pulse: assert property (tx_ovf |=> !tx_ovf)
    else $error("overflow longer than one cycle");
  a_abort_eop: assert property (tx_ena && tx_err |-> tx_eop)
    else $error("abort without end of packet");
  a_err_valid: assert property (rx_err |-> rx_val)
    else $error("receive error without valid");
  a_err_holds: assert property (rx_val && bad_q |-> rx_err)
    else $error("receive error dropped before end");
  a_word_stands: assert property (rx_val && !rx_ena |=>
    rx_val && $stable(rx_dat) && $stable(rx_eop))
    else $error("receive word changed while stalled");
  a_sop_first: assert property (rx_val |-> rx_sop == !in_q)
    else $error("start marker out of place");
  a_size_cap: assert property (rx_val && cnt_q == LAST |-> rx_eop)
    else $error("packet longer than the size cap");
  a_dav_deliver: assert property (pkt_waiting |-> ##[1:3] rx_val)
    else $error("waiting packet not presented");
endmodule // slbp_monitor

// ### slbp_pkg.sv
// types shared by the two ends of the packet buffer port
// assumes slbp_cfg.svh is on the include path
`include "slbp_cfg.svh"

package slbp_pkg;

  // receive delivery: waiting for a packet or block, or mid-packet
  typedef enum logic {
    SLBP_RD_IDLE,
    SLBP_RD_BUSY
  } slbp_rd_state_t;

  // user end receive: passing a packet or skipping the rest of one
  typedef enum logic {
    SLBP_UR_PASS,
    SLBP_UR_SKIP
  } slbp_ur_state_t;

endpackage

// ### slbp_port_if.sv
// packet data port between the link device and the transport logic
// assumes both ends share one clock; no clocking block
`timescale 1ns/1ps

interface slbp_port_if #(
  parameter int unsigned W = 32
);
  logic         tx_ena;
  logic         tx_sop;
  logic         tx_eop;
  logic         tx_err;
  logic [W-1:0] tx_dat;
  logic         tx_dav;
  logic         tx_ovf;
  logic         rx_ena;
  logic         rx_dav;
  logic         rx_val;
  logic         rx_sop;
  logic         rx_eop;
  logic         rx_err;
  logic [W-1:0] rx_dat;

  modport dev (
    input  tx_ena, tx_sop, tx_eop, tx_err, tx_dat, rx_ena,
    output tx_dav, tx_ovf, rx_dav, rx_val, rx_sop, rx_eop, rx_err, rx_dat
  );

  modport usr (
    output tx_ena, tx_sop, tx_eop, tx_err, tx_dat, rx_ena,
    input  tx_dav, tx_ovf, rx_dav, rx_val, rx_sop, rx_eop, rx_err, rx_dat
  );
endinterface // slbp_port_if

// ### slbp_user.sv
// transport end of the packet port: feeds and drains the device
// assumes the device end on the same clock through slbp_port_if
`timescale 1ns/1ps
`include "slbp_cfg.svh"

module slbp_user
  import slbp_pkg::*;
#(
  parameter int unsigned W = `SLBP_WIDTH // [RULE19]
) (
  input  wire logic         i_clock,
  input  wire logic         i_arst_n,
  slbp_port_if.usr          port,
  input  wire logic         i_snd_val,
  output wire logic         o_snd_rdy,
  input  wire logic         i_snd_sop,
  input  wire logic         i_snd_eop,
  input  wire logic         i_snd_abort,
  input  wire logic [W-1:0] i_snd_dat,
  output wire logic         o_rcv_val,
  input  wire logic         i_rcv_rdy,
  output wire logic         o_rcv_sop,
  output wire logic         o_rcv_eop,
  output wire logic         o_rcv_bad,
  output wire logic [W-1:0] o_rcv_dat,
  output wire logic         o_ovf_seen
);
  typedef struct packed {
    slbp_ur_state_t st;
    logic           val;
    logic           sop;
    logic           eop;
    logic           bad;
    logic [W-1:0]   dat;
    logic           ovf;
  } slbp_user_state_t;

  slbp_user_state_t q;
  slbp_user_state_t d;
  logic             take;

  // one word may sit in the output stage; reading stalls behind it
  assign take = port.rx_val && port.rx_ena;

  always_comb begin
    d     = q;
    d.ovf = port.tx_ovf;
    if (q.val && i_rcv_rdy) begin
      d.val = 1'b0;
    end
    if (take) begin
      unique case (q.st)
        SLBP_UR_PASS: begin
          d.val = 1'b1;
          d.sop = port.rx_sop;
          d.eop = port.rx_eop | port.rx_err;
          d.bad = port.rx_err;                                 // [RULE7]
          d.dat = port.rx_dat;
          if (port.rx_err && !port.rx_eop) begin
            d.st = SLBP_UR_SKIP;                               // [RULE7]
          end
        end
        SLBP_UR_SKIP: begin
          if (port.rx_eop) begin
            d.st = SLBP_UR_PASS;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q    <= '0;
      q.st <= SLBP_UR_PASS;
    end else begin
      q <= d;
    end
  end

  assign port.rx_ena = !q.val || i_rcv_rdy;
  // a start is offered even without space; the device judges lateness
  assign port.tx_ena = i_snd_val && (port.tx_dav || i_snd_sop); // [RULE10]
  // an abort becomes error plus end-of-packet on one word
  assign port.tx_sop = i_snd_sop;
  assign port.tx_eop = i_snd_eop | i_snd_abort;                // [RULE8]
  assign port.tx_err = i_snd_abort;                            // [RULE8]
  assign port.tx_dat = i_snd_dat;
  assign o_snd_rdy   = port.tx_dav || i_snd_sop;
  assign o_rcv_val   = q.val;
  assign o_rcv_sop   = q.sop;
  assign o_rcv_eop   = q.eop;
  assign o_rcv_bad   = q.bad;
  assign o_rcv_dat   = q.dat;
  assign o_ovf_seen  = q.ovf;
endmodule // slbp_user

// ### tb_serial_link_packet_buffer_port.sv
// bench: user end and device end joined by the port, link side driven
// assumes design files and slbp_monitor.sv are compiled first
`timescale 1ns/1ps

module tb_serial_link_packet_buffer_port
  import slbp_pkg::*;
;
  localparam int unsigned W = 32;
  typedef struct packed {
    logic [W-1:0] dat;
    logic         sop;
    logic         eop;
    logic         flg;
    logic         any;
  } slbp_note_t;

  logic         i_clock = 1'b0, i_arst_n = 1'b0;
  logic         snd_val = 0, snd_sop = 0, snd_eop = 0, snd_abort = 0;
  logic [W-1:0] snd_dat = '0, lk_rx_dat = '0, d0;
  logic         rcv_rdy = 0, lk_tx_rdy = 0, stall_tx = 0;
  logic         lk_rx_val = 0, lk_rx_sop = 0, lk_rx_eop = 0;
  logic         lk_crc = 0, lk_stomp = 0, lk_restart = 0;
  logic         lk_sym = 0, lk_char = 0, lk_ack = 0;
  logic [31:0]  rs = 32'h0000000c, r;
  logic [7:0]   crc_n = 8'h00, na_n = 8'h00, ovf_n = 8'h00;
  wire          snd_rdy, rcv_val, rcv_sop, rcv_eop, rcv_bad, ovf_seen;
  wire          tx_val, tx_sop, tx_eop, tx_stomp, crc_err, not_acc;
  wire [W-1:0]  rcv_dat, tx_dat;
  int           error_cnt = 0, compares = 0, k;
  slbp_note_t   txq[$], rxq[$], h;

  slbp_port_if #(.W(W)) pif ();
  // smaller buffer so the stalled fill runs out of room; the size-capped packet still fits
  slbp_dev #(.W(W), .BUF_BYTES(1024)) i_slbp_dev (
    .i_clock(i_clock), .i_arst_n(i_arst_n), .port(pif.dev),
    .o_lk_tx_val(tx_val), .i_lk_tx_rdy(lk_tx_rdy), .o_lk_tx_sop(tx_sop),
    .o_lk_tx_eop(tx_eop), .o_lk_tx_stomp(tx_stomp), .o_lk_tx_dat(tx_dat),
    .i_lk_rx_val(lk_rx_val), .i_lk_rx_sop(lk_rx_sop),
    .i_lk_rx_eop(lk_rx_eop), .i_lk_rx_dat(lk_rx_dat),
    .i_lk_crc_err(lk_crc), .i_lk_stomp(lk_stomp),
    .i_lk_restart(lk_restart), .i_lk_sym_err(lk_sym),
    .i_lk_char_err(lk_char), .i_lk_ack_full(lk_ack),
    .o_crc_err(crc_err), .o_not_accepted(not_acc));
  slbp_user #(.W(W)) i_slbp_user (
    .i_clock(i_clock), .i_arst_n(i_arst_n), .port(pif.usr),
    .i_snd_val(snd_val), .o_snd_rdy(snd_rdy), .i_snd_sop(snd_sop),
    .i_snd_eop(snd_eop), .i_snd_abort(snd_abort), .i_snd_dat(snd_dat),
    .o_rcv_val(rcv_val), .i_rcv_rdy(rcv_rdy), .o_rcv_sop(rcv_sop),
    .o_rcv_eop(rcv_eop), .o_rcv_bad(rcv_bad), .o_rcv_dat(rcv_dat),
    .o_ovf_seen(ovf_seen));
  slbp_monitor #(.W(W)) i_slbp_monitor (
    .i_clock(i_clock), .i_arst_n(i_arst_n), .tx_ena(pif.tx_ena),
    .tx_sop(pif.tx_sop), .tx_eop(pif.tx_eop), .tx_err(pif.tx_err),
    .tx_dat(pif.tx_dat), .tx_dav(pif.tx_dav), .tx_ovf(pif.tx_ovf),
    .rx_ena(pif.rx_ena), .rx_dav(pif.rx_dav), .rx_val(pif.rx_val),
    .rx_sop(pif.rx_sop), .rx_eop(pif.rx_eop), .rx_err(pif.rx_err),
    .rx_dat(pif.rx_dat));

  initial begin
    forever #4 i_clock = ~i_clock;
  end

  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  task automatic cmp(input logic [W+2:0] g, input logic [W+2:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic cmp_n(input logic [7:0] g, input logic [7:0] e);
    cmp({{(W-5){1'b0}}, g}, {{(W-5){1'b0}}, e});
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one word to the send side, held until taken
  task automatic snd(input logic s, input logic e, input logic a);
    int n;
    n = 0;
    d0 = rnd();
    txq.push_back('{a ? '0 : d0, s & !a, e, a, !a});
    snd_val <= 1'b1; snd_sop <= s; snd_eop <= e;
    snd_abort <= a; snd_dat <= d0;
    do begin
      @(posedge i_clock);
      n++;
    end while (snd_rdy !== 1'b1 && n < 500);
  endtask

  task automatic tpkt(input int n, input logic ab);
    for (int i = 0; i < n; i++) snd(i == 0, i == n - 1, ab && i == n - 1);
    snd_val <= 1'b0;
    @(posedge i_clock);
  endtask

  task automatic lkw(input logic v, s, e, input logic [2:0] ev,
                     input logic [W-1:0] d);
    lk_rx_val <= v; lk_rx_sop <= s; lk_rx_eop <= e; lk_rx_dat <= d;
    lk_crc <= ev == 3'h1; lk_ack <= ev == 3'h2; lk_sym <= ev == 3'h3;
    lk_char <= ev == 3'h4; lk_stomp <= ev == 3'h5;
    lk_restart <= ev == 3'h6;
    @(posedge i_clock);
  endtask

  // link packet; event in an idle cycle before word c, after the words if c == n, on eop if c < 0
  task automatic rpkt(input int n, c, input logic [2:0] ev, input logic b);
    logic e;
    if (b) rxq.push_back('{'0, 1'b0, 1'b1, 1'b1, 1'b0});
    for (int i = 0; i < n; i++) begin
      if (i == c) lkw(1'b0, 1'b0, 1'b0, ev, '0);
      d0 = rnd();
      e = i == n - 1 && c != n;
      if (!b) rxq.push_back('{d0, i == 0, e, 1'b0, 1'b1});
      lkw(1'b1, i == 0, e, (c < 0 && e) ? ev : 3'h0, d0);
    end
    if (c == n) lkw(1'b0, 1'b0, 1'b0, ev, '0);
    lkw(1'b0, 1'b0, 1'b0, 3'h0, '0);
  endtask

  always @(posedge i_clock) begin
    r = rnd();
    lk_tx_rdy <= !stall_tx && |r[1:0];
    rcv_rdy <= |r[3:2];
    crc_n <= crc_n + crc_err;
    na_n <= na_n + not_acc;
    ovf_n <= ovf_n + ovf_seen;
    if (tx_val === 1'b1 && lk_tx_rdy) begin
      h = txq.pop_front();
      cmp({h.any ? tx_dat : h.dat, tx_sop, tx_eop, tx_stomp},
          {h.dat, h.sop, h.eop, h.flg});
    end
    if (rcv_val === 1'b1 && rcv_rdy && (!rxq[0].any ? rcv_eop : 1'b1)) begin
      h = rxq.pop_front();
      cmp({h.any ? rcv_dat : h.dat, h.any ? rcv_sop : h.sop, rcv_eop,
          rcv_bad}, {h.dat, h.sop, h.eop, h.flg});
    end
  end

  initial begin
    repeat (4) @(posedge i_clock);
    i_arst_n <= 1'b1;
    @(posedge i_clock);
    tpkt(1, 1'b0);
    tpkt(5, 1'b0);
    tpkt(6, 1'b1);
    rpkt(3, -1, 3'h0, 1'b0);
    rpkt(20, -1, 3'h0, 1'b0);
    rpkt(69, -1, 3'h0, 1'b0);
    rpkt(75, -1, 3'h0, 1'b1);
    rpkt(4, -1, 3'h1, 1'b1);
    rpkt(4, -1, 3'h2, 1'b1);
    rpkt(4, -1, 3'h3, 1'b1);
    rpkt(6, 2, 3'h4, 1'b1);
    rpkt(3, 3, 3'h5, 1'b1);
    rpkt(2, -1, 3'h0, 1'b1);
    lkw(1'b0, 1'b0, 1'b0, 3'h6, '0);
    rpkt(3, -1, 3'h0, 1'b0);
    // link stalled: fill until the send side refuses
    stall_tx <= 1'b1;
    k = 0;
    while (pif.tx_dav === 1'b1 && k < 400) begin
      tpkt(1, 1'b0);
      k++;
    end
    snd_sop <= 1'b0;
    repeat (8) @(posedge i_clock);
    cmp_n({7'h00, snd_rdy}, 8'h00);
    // start long after space dropped: dropped, never on the link
    tpkt(1, 1'b0);
    void'(txq.pop_back());
    stall_tx <= 1'b0;
    k = 0;
    while ((txq.size() || rxq.size()) && k < 3000) begin
      @(posedge i_clock);
      k++;
    end
    cmp_n(8'(txq.size() + rxq.size()), 8'h00);
    cmp_n(crc_n, 8'h01);
    cmp_n(na_n, 8'h03);
    cmp_n(ovf_n, 8'h01);
    wrap_up();
  end

  // about 50000 cycles, far beyond the expected run
  initial begin
    #400000;
    error_cnt++;
    wrap_up();
  end
endmodule // tb_serial_link_packet_buffer_port
